/* power_off_pkg.sv */
// Purpose: Shared constants for the power-off controller and its helpers.
// Assumes: One 250 MHz clock; the slow clock is an enable pulse from a divider.
// Notes on behaviour
// - The controller runs on every slow-clock enable, with no gating by power management.
// - A keyed one in command bit 0 asserts the power-off request, and a zero does nothing.
// - A command write whose upper key byte is not 0xa5 is discarded whole.
// - The two-bit edge select picks none, rising, falling or any change of the wake input.
// - A selected edge starts the debounce counter; reaching its count releases the request.
// - Another wake input change before the count is reached clears the counter and restarts it if the change is a selected edge.
// - The four-bit debounce count is in units of sixteen slow-clock cycles of stable input.
// - Release comes count times sixteen plus one slow-clock cycles after the wake event.
// - A wake event sets a sticky status flag that a read of the status register clears.
`default_nettype none

package power_off_pkg;

  // Register byte offsets.
  localparam logic [7:0]  OFS_COMMAND     = 8'h00;
  localparam logic [7:0]  OFS_WAKE_CFG    = 8'h04;
  localparam logic [7:0]  OFS_WAKE_STATUS = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1c;

  // Command register fields.
  localparam int          CMD_OFF_BIT     = 0;
  localparam int          KEY_LSB         = 24;
  localparam logic [7:0]  COMMAND_KEY     = 8'ha5;

  // Configuration register fields.
  localparam int          EDGE_LSB        = 0;
  localparam int          COUNT_LSB       = 4;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0103;
  localparam logic [31:0] CFG_WMASK       = 32'h0000_01f3;

  // Status and mask register fields.
  localparam int          WAKE_FLAG_BIT   = 0;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;

  // Debounce unit in slow-clock cycles.
  localparam int          DEBOUNCE_UNIT   = 16;

  // Wake edge selections.
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_ANY
  } wake_edge_t;

endpackage : power_off_pkg

`default_nettype wire

/* slow_tick_divider.sv */
// Purpose: Divides the bus clock into a one-cycle slow-clock enable pulse.
// Assumes: The ratio is at least two.
// Notes: The pulse runs free from reset onward.
`default_nettype none

module slow_tick_divider #(
  parameter int RATIO = 8
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Enable out.
  output logic      slow_tick
);

  localparam int CW = $clog2(RATIO);
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

  logic [CW-1:0] div_ff;
  logic          tick_ff;
  wire           wrap = (div_ff == LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= wrap ? '0 : div_ff + 1'b1;
      tick_ff <= wrap;
    end
  end

  assign slow_tick = tick_ff;

endmodule : slow_tick_divider

`default_nettype wire

/* wake_debounce.sv */
// Purpose: Detects the selected wake transition and debounces it on slow ticks.
// Assumes: The wake input is synchronous to hclk.
// Notes: wake_fire is a one-cycle pulse when the stable time has passed.
`default_nettype none

module wake_debounce
  import power_off_pkg::*;
#(
  parameter int CW = 8
) (
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       slow_tick,
  // Configuration.
  input  wire logic [1:0] wake_edge_select,
  input  wire logic [3:0] wake_debounce_count,
  // Wake input and event.
  input  wire logic       wake_input_zero,
  output logic            wake_fire
);

  logic          smp_ff;
  logic          prev_ff;
  logic          primed_ff;
  logic          run_ff;
  logic [CW-1:0] cnt_ff;
  logic          fire_ff;

  // Target in slow cycles.
  wire [CW-1:0] target = CW'(wake_debounce_count) * CW'(DEBOUNCE_UNIT);
  wire          change = smp_ff ^ prev_ff;
  wire          rise   = smp_ff & ~prev_ff;
  wire          fall   = ~smp_ff & prev_ff;
  wire          sel    = ((wake_edge_select == EDGE_RISE) & rise) |
                         ((wake_edge_select == EDGE_FALL) & fall) |
                         ((wake_edge_select == EDGE_ANY) & change);
  wire          active = (wake_edge_select != EDGE_NONE);
  wire          done   = run_ff & active & !change & (cnt_ff + 1'b1 >= target);
  wire          hit0   = sel & (target == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_ff  <= 1'b0;
      prev_ff <= 1'b0;
      primed_ff <= 1'b0;
      run_ff  <= 1'b0;
      cnt_ff  <= '0;
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= 1'b0;
      if (slow_tick) begin
        // The first tick loads both stages, so a pin idling high gives no false edge.
        smp_ff    <= wake_input_zero;
        prev_ff   <= primed_ff ? smp_ff : wake_input_zero;
        primed_ff <= 1'b1;
        fire_ff   <= done | hit0;
        if (change | !active) begin
          cnt_ff <= '0;
          run_ff <= sel & !hit0;
        end else if (done) begin
          cnt_ff <= '0;
          run_ff <= 1'b0;
        end else if (run_ff) begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  assign wake_fire = fire_ff;

endmodule : wake_debounce

`default_nettype wire

/* power_off_controller.sv */
// Purpose: Power-off controller with keyed command, wake debounce and AHB-Lite registers.
// Assumes: Single AHB-Lite slave, word transfers, zero wait states.
// Notes: The slow clock is an enable pulse derived inside from hclk.
//
// The AHB-Lite register port was decided locally.
`default_nettype none

module power_off_controller
  import power_off_pkg::*;
#(
  parameter int SLOW_RATIO = 8
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins.
  input  wire logic        wake_input_zero,
  output logic             power_off_request,
  // Interrupt.
  output logic             irq
);

  // Slow-clock enable.
  logic slow_tick;

  slow_tick_divider #(
    .RATIO     (SLOW_RATIO)
  ) u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .slow_tick (slow_tick)
  );

  // Register state.
  logic [31:0] cfg_ff;
  logic [31:0] status_ff;
  logic [31:0] mask_ff;
  logic        off_ff;
  logic        irq_ff;
  logic [31:0] rdata_ff;
  logic        ready_ff;
  logic        resp_ff;

  // Data-phase write capture.
  logic        wr_pend_ff;
  logic [7:0]  wr_ofs_ff;

  logic [31:0] nxt_cfg;
  logic [31:0] nxt_status;
  logic [31:0] nxt_mask;
  logic        nxt_off;
  logic        nxt_irq;
  logic [31:0] nxt_rdata;

  // Wake detection.
  logic wake_fire;

  wake_debounce #(
    .CW                  (8)
  ) u_wake (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .slow_tick           (slow_tick),
    .wake_edge_select    (cfg_ff[EDGE_LSB +: 2]),
    .wake_debounce_count (cfg_ff[COUNT_LSB +: 4]),
    .wake_input_zero     (wake_input_zero),
    .wake_fire           (wake_fire)
  );

  // Address decode.
  function automatic logic is_reg(input logic [7:0] ofs, input logic [7:0] ref_ofs);
    is_reg = (ofs == ref_ofs);
  endfunction : is_reg

  wire        addr_phase = hsel & htrans[1] & hready;
  wire [7:0]  a_ofs      = haddr[7:0];
  wire        a_mapped   = (haddr[31:8] == 24'h00_0000);
  wire        rd_now     = addr_phase & !hwrite & a_mapped;
  wire        wr_now     = addr_phase & hwrite & a_mapped;

  wire        rd_cfg     = rd_now & is_reg(a_ofs, OFS_WAKE_CFG);
  wire        rd_status  = rd_now & is_reg(a_ofs, OFS_WAKE_STATUS);
  wire        rd_mask    = rd_now & is_reg(a_ofs, OFS_IRQ_MASK);

  wire        wr_cmd     = wr_pend_ff & is_reg(wr_ofs_ff, OFS_COMMAND);
  wire        wr_cfg     = wr_pend_ff & is_reg(wr_ofs_ff, OFS_WAKE_CFG);
  wire        wr_mask    = wr_pend_ff & is_reg(wr_ofs_ff, OFS_IRQ_MASK);

  // Keyed command decode.
  wire        key_ok     = (hwdata[KEY_LSB +: 8] == COMMAND_KEY);
  wire        cmd_off    = wr_cmd & key_ok & hwdata[CMD_OFF_BIT];

  // Read data, registered at the address phase.
  assign nxt_rdata = rd_cfg    ? cfg_ff    :
                     rd_status ? status_ff :
                     rd_mask   ? mask_ff   :
                                 32'h0000_0000;

  // Configuration write.
  assign nxt_cfg = wr_cfg ? (hwdata & CFG_WMASK) : cfg_ff;

  // Mask write.
  assign nxt_mask = wr_mask ? (hwdata & 32'h0000_0001) : mask_ff;

  // Sticky flag: a read clears, a wake event in the same cycle wins.
  assign nxt_status = wake_fire ? (status_ff | (32'h0000_0001 << WAKE_FLAG_BIT)) :
                      rd_status ? STATUS_RESET :
                                  status_ff;

  // Request: set by keyed command, cleared only by a wake event.
  assign nxt_off = cmd_off   ? 1'b1 :
                   wake_fire ? 1'b0 :
                               off_ff;

  // Level interrupt from unmasked status.
  assign nxt_irq = |(nxt_status & nxt_mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 8'h00;
    end else begin
      wr_pend_ff <= wr_now;
      wr_ofs_ff  <= a_ofs;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff    <= CFG_RESET;
      status_ff <= STATUS_RESET;
      mask_ff   <= MASK_RESET;
    end else begin
      cfg_ff    <= nxt_cfg;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      off_ff <= nxt_off;
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b1;
      resp_ff  <= 1'b0;
    end else begin
      rdata_ff <= addr_phase ? nxt_rdata : rdata_ff;
      ready_ff <= 1'b1;
      resp_ff  <= 1'b0;
    end
  end

  // Outputs come straight from flip-flops.
  assign hrdata            = rdata_ff;
  assign hreadyout         = ready_ff;
  assign hresp             = resp_ff;
  assign power_off_request = off_ff;
  assign irq               = irq_ff;

endmodule : power_off_controller

`default_nettype wire

/* power_off_controller_assertions.sv */
// Purpose: Port checker for the power-off controller.
// Assumes: One clock; hresetn is async, active low.
// Notes: Tracks the data phase and the wake configuration.
`default_nettype none
module power_off_chk
  import power_off_pkg::*;
#(parameter int SLOW_RATIO = 8) (
  // Bus.
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins.
  input wire logic        wake_input_zero,
  input wire logic        power_off_request,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [9:0] dp_ff;
  logic [8:0] cfg_ff;
  logic       wk_ff;
  int         stab_ff;
  wire logic  take = hsel & htrans[1] & hready;
  wire logic  acc  = take | dp_ff[9] | dp_ff[8];
  wire logic  cmd  = dp_ff[9] && dp_ff[7:0] == OFS_COMMAND && hwdata[CMD_OFF_BIT]
                     && hwdata[31:24] == COMMAND_KEY;
  wire logic  zrd  = dp_ff[8]
                     && !(dp_ff[7:0] inside {OFS_WAKE_CFG, OFS_WAKE_STATUS, OFS_IRQ_MASK});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_ff   <= '0;
      cfg_ff  <= CFG_RESET[8:0];
      wk_ff   <= 1'b0;
      stab_ff <= 0;
    end else begin
      dp_ff   <= {take & hwrite, take & ~hwrite, haddr[7:0]};
      wk_ff   <= wake_input_zero;
      stab_ff <= (wake_input_zero != wk_ff) ? 0 : stab_ff + 1;
      if (dp_ff[9] && dp_ff[7:0] == OFS_WAKE_CFG) begin
        cfg_ff <= hwdata[8:0] & CFG_WMASK[8:0];
      end
    end
  end
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  AST_KEY_SET: assert property (cmd |=> power_off_request)
    else $error("keyed command lost");
  AST_KEY_ONLY: assert property (
    !power_off_request && !cmd |=> !power_off_request) else $error("request without key");
  AST_NONE_HOLD: assert property (
    power_off_request && cfg_ff[1:0] == 2'h0 |=> power_off_request) else $error("woke when off");
  AST_FALL_STABLE: assert property (
    $fell(power_off_request) |-> stab_ff + 3 * SLOW_RATIO >= cfg_ff[7:4] * 16 * SLOW_RATIO)
    else $error("release too early");
  AST_IRQ_HOLD: assert property (
    irq && !acc && !$past(acc) |=> irq) else $error("flag lost unread");
  AST_ZERO_READ: assert property (zrd |-> hrdata == 32'h0)
    else $error("nonzero empty read");
  AST_CFG_READ: assert property (
    dp_ff[8] && dp_ff[7:0] == OFS_WAKE_CFG |-> hrdata == {23'h0, cfg_ff}) else $error("cfg read");
  cover property ($fell(power_off_request));
  cover property (cmd);
  cover property ($rose(irq));
endmodule : power_off_chk
bind power_off_controller power_off_chk #(.SLOW_RATIO(SLOW_RATIO)) chk (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .wake_input_zero, .power_off_request, .irq);
`default_nettype wire

/* wake_button_model.sv */
// Purpose: Wake button and supply converter beside the controller.
// Assumes: The bench sets the pressed level and the bounce length.
// Notes: A change bounces each cycle before it settles.
`default_nettype none
module wake_button_model (
  // Control.
  input wire logic       hclk,
  input wire logic       press,
  input wire logic [3:0] bounce,
  // Pins.
  input wire logic       power_off_request,
  output logic           wake_input_zero,
  output logic           supply_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_ff = 1'b0;
  logic [3:0] left_ff = 4'h0;
  assign wake_input_zero = last_ff ^ left_ff[0];
  assign supply_on       = ~power_off_request;
  always_ff @(posedge hclk) begin
    left_ff <= (press != last_ff) ? bounce : left_ff - {3'h0, left_ff != 4'h0};
    last_ff <= press;
  end
endmodule : wake_button_model
`default_nettype wire

/* power_off_controller_tb.sv */
// Purpose: Self-checking bench for the power-off controller.
// Assumes: One slow tick every two hclk cycles.
// Notes: Read data is compared with queued notes.
`default_nettype none
module power_off_controller_tb
  import power_off_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
  logic        press = 1'b0, hreadyout, hresp, wake, por, irq, supply_on;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, exp_q[$];
  logic [3:0]  bounce = 4'h0;
  logic [7:0]  seed = 8'h23;
  int          mismatches = 0, num_checks = 0;
  always #2 hclk = ~hclk;
  power_off_controller #(.SLOW_RATIO(2)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .wake_input_zero(wake), .power_off_request(por), .irq);
  wake_button_model partner (.hclk, .press, .bounce, .power_off_request(por),
    .wake_input_zero(wake), .supply_on);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic wait_for(ref logic s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== v && n < 400);
    if (s !== v) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_for
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_for(hreadyout, 1'b1, n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !wr;
    if (!wr) exp_q.push_back(d);
    wait_for(hreadyout, 1'b1, n);
    rd_dp <= 1'b0;
  endtask : bus
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) check("read", hrdata, exp_q.pop_front());
  end
  initial begin
    int c, n;
    logic pre;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, OFS_WAKE_CFG, CFG_RESET);
    bus(0, OFS_WAKE_STATUS, STATUS_RESET);
    bus(0, OFS_COMMAND, 32'h0);
    bus(0, 8'h40, 32'h0);
    seed = lfsr(seed);
    bus(1, OFS_COMMAND, {(seed == COMMAND_KEY) ? 8'h0 : seed, 24'h1});
    bus(1, OFS_COMMAND, {COMMAND_KEY, 24'h0});
    @(posedge hclk);
    check("request", por, 0);
    for (int m = 1; m < 4; m++) begin
      pre = (m == 2);
      seed = lfsr(seed);
      c = 1 + seed % 3;
      bus(1, OFS_WAKE_CFG, 32'h0);
      bus(1, OFS_IRQ_MASK, {31'h0, m != 2});
      bus(1, OFS_COMMAND, {COMMAND_KEY, 24'h1});
      bus(1, OFS_COMMAND, {COMMAND_KEY, 24'h1});
      press <= !pre;
      repeat (40) @(posedge hclk);
      press <= pre;
      @(posedge hclk);
      check("request", por, 1);
      bus(1, OFS_WAKE_CFG, {24'h0, c[3:0], 2'h0, m[1:0]});
      press <= !pre;
      repeat (2 + seed[7:4] % 12) @(posedge hclk);
      press <= pre;
      repeat (20) @(posedge hclk);
      @(posedge hclk);
      check("request", por, 1);
      bounce <= 4'h5;
      press <= !pre;
      wait_for(por, 1'b0, n);
      check("release", n >= 32 * c + 4 && n <= 32 * c + 20, 1);
      check("supply", supply_on, 1);
      @(posedge hclk);
      check("irq", irq, m != 2);
      bus(0, OFS_WAKE_STATUS, 32'h1);
      bus(0, OFS_WAKE_STATUS, 32'h0);
      @(posedge hclk);
      check("irq", irq, 0);
      bounce <= 4'h0;
    end
    bus(1, OFS_WAKE_CFG, 32'h0000_0003);
    bus(1, OFS_COMMAND, {COMMAND_KEY, 24'h1});
    press <= 1'b0;
    wait_for(por, 1'b0, n);
    check("release", n >= 4 && n <= 12, 1);
    bus(0, OFS_WAKE_STATUS, 32'h1);
    finish_test();
  end
endmodule : power_off_controller_tb
`default_nettype wire
